// [dv/ssp_far_end.sv]
// far end model: bit clock master of the synchronous channel
`timescale 1ns/10ps

module ssp_far_end (
  // clock
  input wire logic clk,
  // channel pins
  output logic sync_bit_clock,
  output logic sync_out_enable,
  output logic sync_in_enable,
  output logic clock_mode_select,
  output logic sync_bit_in,
  input wire logic sync_bit_out,
  input wire logic sync_bit_out_oe
);
  initial begin
    sync_bit_clock = 1'h0;
    sync_out_enable = 1'h0;
    sync_in_enable = 1'h0;
    clock_mode_select = 1'h0;
    sync_bit_in = 1'h0;
  end

  // one bit period of 8 clocks, bit clock high half first
  task automatic tick(input logic en, input logic bi, output logic bo);
    @(posedge clk);
    sync_bit_clock <= 1'h1;
    sync_in_enable <= en;
    if (clock_mode_select) sync_out_enable <= en;
    sync_bit_in <= bi;
    repeat (4) @(posedge clk);
    sync_bit_clock <= 1'h0;
    if (!clock_mode_select) sync_out_enable <= en;
    repeat (2) @(posedge clk);
    // released line has no pull: model it as the inverse
    bo = sync_bit_out_oe ? sync_bit_out : ~sync_bit_out;
    @(posedge clk);
  endtask

  // frame end: clock parked low, enables dropped, data line inverted
  task automatic stop();
    @(posedge clk);
    sync_out_enable <= 1'h0;
    if (clock_mode_select) begin
      sync_in_enable <= 1'h0;
    end else begin
      // spare clock pulse: input enable may only fall while it is high
      @(posedge clk);
      sync_bit_clock <= 1'h1;
      repeat (2) @(posedge clk);
      sync_in_enable <= 1'h0;
      repeat (2) @(posedge clk);
      sync_bit_clock <= 1'h0;
    end
    sync_bit_in <= ~sync_bit_in;
  endtask

  // mode change between frames, clock parked
  task automatic set_mode(input logic burst_on);
    @(posedge clk);
    clock_mode_select <= burst_on;
  endtask
endmodule : ssp_far_end

// [dv/ssp_sync_port_properties.sv]
// assertions on the ports of the synchronous channel serial port
`timescale 1ns/10ps

module ssp_sync_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // channel and status
  input wire logic sync_bit_clock,
  input wire logic sync_out_enable,
  input wire logic clock_mode_select,
  input wire logic sync_bit_out,
  input wire logic sync_bit_out_oe,
  input wire logic tx_room_status,
  input wire logic rx_framing_status
);
  // ==========================================================
  // bit clock edges, burst count, age of last falling edge
  logic bclk_d_reg;
  logic [3:0] bcnt_reg;
  logic [3:0] fage_reg;
  wire bclk_rise = sync_bit_clock & ~bclk_d_reg;
  wire bclk_fall = bclk_d_reg & ~sync_bit_clock;
  wire [3:0] bcnt_next = !sync_out_enable ? 4'h0 :
    (bclk_rise && bcnt_reg != 4'hf) ? bcnt_reg + 4'h1 : bcnt_reg;
  wire [3:0] fage_next = bclk_fall ? 4'h0 :
    (fage_reg == 4'hf) ? fage_reg : fage_reg + 4'h1;
  always_ff @(posedge clk) begin
    bclk_d_reg <= sync_bit_clock;
    bcnt_reg <= bcnt_next;
    fage_reg <= fage_next;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_release;
    $rose(rstn);
  endsequence
  sequence s_room_up;
    !tx_room_status && !rx_framing_status && !sync_bit_out_oe
      ##1 tx_room_status;
  endsequence
  a_reset_release: assert property (s_release |-> s_room_up)
    else $error("status lines wrong at reset release");
  a_oe_follow: assert property (
    sync_bit_out_oe == $past(sync_out_enable, 3))
    else $error("output enable does not follow pin");
  a_out_launch: assert property (
    $changed(sync_bit_out) && sync_bit_out_oe && $past(sync_bit_out_oe)
    |-> (clock_mode_select ?
      ($past(sync_bit_clock, 3) && !$past(sync_bit_clock, 4)) :
      (!$past(sync_bit_clock, 3) && $past(sync_bit_clock, 4))))
    else $error("output bit changed off its launch edge");
  a_burst_hold: assert property (
    clock_mode_select && bclk_rise && bcnt_reg >= 4'h8
    |-> ##3 $stable(sync_bit_out))
    else $error("burst sent more than eight bits");
  a_framing_rise: assert property (
    $rose(rx_framing_status) |-> fage_reg < 4'h8)
    else $error("framing rose away from a capture");
  a_wait_one: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_wait_idle: assert property (!avs_read && !avs_write
    |-> !avs_waitrequest)
    else $error("wait raised with no request");
  a_room_write: assert property (avs_write && !avs_waitrequest
    && avs_address == ssp_pkg::REG_TX_DATA && tx_room_status
    |=> !tx_room_status)
    else $error("room status stayed high after a write");
endmodule : ssp_sync_port_properties

bind ssp_sync_port ssp_sync_port_properties i_ssp_sync_port_properties (
  .clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
  .sync_bit_clock, .sync_out_enable, .clock_mode_select, .sync_bit_out,
  .sync_bit_out_oe, .tx_room_status, .rx_framing_status);

// [dv/ssp_sync_port_tb_top.sv]
// self-checking testbench of the synchronous channel serial port
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end

module ssp_sync_port_tb_top;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sync_bit_clock, sync_out_enable, sync_in_enable;
  logic clock_mode_select, sync_bit_in, sync_bit_out, sync_bit_out_oe;
  logic tx_room_status, rx_framing_status;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [31:0] bits;

  always #50 clk = ~clk;

  ssp_sync_port i_ssp_sync_port (.clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .sync_bit_clock, .sync_out_enable, .sync_in_enable, .clock_mode_select,
    .sync_bit_in, .sync_bit_out, .sync_bit_out_oe, .tx_room_status,
    .rx_framing_status);
  ssp_far_end i_ssp_far_end (.clk, .sync_bit_clock, .sync_out_enable,
    .sync_in_enable, .clock_mode_select, .sync_bit_in, .sync_bit_out,
    .sync_bit_out_oe);

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic bus(input logic rdn, input logic [3:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= rdn;
    avs_write <= !rdn;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'h0) begin
      miscompares++;
      final_report();
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask : bus

  task automatic frame(input int n, input logic [31:0] inb);
    logic b;
    for (int i = 0; i < n; i++) begin
      i_ssp_far_end.tick(1'h1, inb[i % 32], b);
      bits[i % 32] = b;
    end
    i_ssp_far_end.stop();
    repeat (4) @(posedge clk);
  endtask : frame

  function automatic logic has_pair(input logic [7:0] a, input logic [7:0] b);
    logic hit;
    hit = 1'h0;
    for (int s = 0; s <= 16; s++)
      if (bits[s +: 8] === a && bits[s + 8 +: 8] === b) hit = 1'h1;
    return hit;
  endfunction : has_pair

  task automatic t_reset();
    `CHK("oe in reset", 1'h0, sync_bit_out_oe)
    `CHK("room in reset", 1'h0, tx_room_status)
    `CHK("framing in reset", 1'h0, rx_framing_status)
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK("room at release", 1'h1, tx_room_status)
    bus(1'h1, ssp_pkg::REG_STATUS, 32'h0);
    `CHK("status word", 32'h1, rd)
    bus(1'h1, 4'hc, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("test reset done");
  endtask : t_reset

  task automatic t_txrx();
    frame(24, 32'h0);
    `CHK("idle flags", 1'h1, has_pair(8'h7e, 8'h7e))
    bus(1'h0, ssp_pkg::REG_TX_DATA, 32'h3c);
    `CHK("room after write", 1'h0, tx_room_status)
    frame(32, 32'h7e7e_a57e);
    `CHK("data sent", 1'h1, has_pair(8'h3c, 8'h7e))
    `CHK("framing", 1'h1, rx_framing_status)
    bus(1'h1, ssp_pkg::REG_STATUS, 32'h0);
    `CHK("status framed", 32'h7, rd)
    bus(1'h1, ssp_pkg::REG_RX_DATA, 32'h0);
    `CHK("byte received", 32'ha5, rd)
    $display("test continuous done");
  endtask : t_txrx

  task automatic t_burst();
    i_ssp_far_end.set_mode(1'h1);
    frame(11, 32'h0000_075a);
    `CHK("burst flag", ssp_pkg::FLAG_BYTE, bits[7:0])
    `CHK("eighth held", {3{ssp_pkg::FLAG_BYTE[7]}}, bits[10:8])
    frame(8, 32'h81);
    `CHK("burst restart", ssp_pkg::FLAG_BYTE, bits[7:0])
    bus(1'h1, ssp_pkg::REG_RX_DATA, 32'h0);
    `CHK("burst byte", 32'h81, rd)
    $display("test burst done");
  endtask : t_burst

  task automatic t_loss();
    i_ssp_far_end.set_mode(1'h0);
    frame(650, 32'h0);
    `CHK("sync lost", 1'h0, rx_framing_status)
    frame(8, 32'h7e);
    `CHK("sync regained", 1'h1, rx_framing_status)
    $display("test sync loss done");
  endtask : t_loss

  task automatic t_midreset();
    bus(1'h0, ssp_pkg::REG_TX_DATA, 32'h55);
    `CHK("room before reset", 1'h0, tx_room_status)
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK("room mid reset", 1'h0, tx_room_status)
    `CHK("framing mid reset", 1'h0, rx_framing_status)
    `CHK("oe mid reset", 1'h0, sync_bit_out_oe)
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK("room after reset", 1'h1, tx_room_status)
    bus(1'h1, ssp_pkg::REG_STATUS, 32'h0);
    `CHK("status cleared", 32'h1, rd)
    frame(24, 32'h0);
    `CHK("flags after reset", 1'h1, has_pair(8'h7e, 8'h7e))
    `CHK("held byte cleared", 1'h0, has_pair(8'h55, 8'h7e))
    $display("test mid-run reset done");
  endtask : t_midreset

  initial begin
    repeat (3) @(posedge clk);
    t_reset();
    t_txrx();
    t_burst();
    t_loss();
    t_midreset();
    final_report();
  end
endmodule : ssp_sync_port_tb_top

// [verilog/ssp_pkg.sv]
// constants and types for the synchronous channel serial port
package ssp_pkg;

  // ==========================================================
  // register map (byte addresses on the slave bus)
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_TX_DATA = 4'h0;
  localparam logic [3:0] REG_RX_DATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // ==========================================================
  // status fields
  localparam int unsigned ST_TX_ROOM = 0;
  localparam int unsigned ST_RX_FRAMING = 1;
  localparam int unsigned ST_RX_VALID = 2;
  localparam int unsigned ST_RX_OVERRUN = 3;

  // ==========================================================
  // line coding
  localparam logic [7:0] FLAG_BYTE = 8'h7e;
  localparam logic [3:0] BURST_BITS = 4'h8;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [5:0] FLAG_EVERY = 6'h3c;
  localparam logic [9:0] SYNC_LOSS_BITS = 10'h280;

  // ==========================================================
  // values after reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ==========================================================
  // sampled pin group
  typedef struct packed {
    logic dc;
    logic oe;
    logic ie;
    logic cm;
    logic din;
  } ssp_pins_type;

endpackage : ssp_pkg

// [verilog/ssp_sync_port.sv]
// synchronous channel serial port with avalon-mm register access
`timescale 1ns/10ps

module ssp_sync_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // synchronous channel
  input wire logic sync_bit_clock,
  input wire logic sync_out_enable,
  input wire logic sync_in_enable,
  input wire logic clock_mode_select,
  input wire logic sync_bit_in,
  output logic sync_bit_out,
  output logic sync_bit_out_oe,
  // status lines
  output logic tx_room_status,
  output logic rx_framing_status
);

  // ==========================================================
  // pin synchronisers
  ssp_pkg::ssp_pins_type pins_raw;
  ssp_pkg::ssp_pins_type pin_meta_reg;
  ssp_pkg::ssp_pins_type pin_sync_reg;
  ssp_pkg::ssp_pins_type pin_last_reg;

  assign pins_raw = '{
    dc: sync_bit_clock,
    oe: sync_out_enable,
    ie: sync_in_enable,
    cm: clock_mode_select,
    din: sync_bit_in
  };

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_last_reg <= '0;
    end else begin
      pin_meta_reg <= pins_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  wire dc_rise = pin_sync_reg.dc & ~pin_last_reg.dc;
  wire dc_fall = ~pin_sync_reg.dc & pin_last_reg.dc;
  wire burst = pin_sync_reg.cm;
  wire oe_on = pin_sync_reg.oe;
  wire ie_on = pin_sync_reg.ie;

  // ==========================================================
  // register bus decode, one wait state per access
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_mux;

  wire bus_req = avs_read | avs_write;
  wire bus_acc = bus_req & ack_reg;
  wire sel_tx = avs_address == ssp_pkg::REG_TX_DATA;
  wire sel_rx = avs_address == ssp_pkg::REG_RX_DATA;
  wire sel_st = avs_address == ssp_pkg::REG_STATUS;

  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  // ==========================================================
  // transmit holding word
  logic [7:0] tx_hold_reg;
  logic tx_full_reg;
  logic tx_room_reg;
  logic tx_take;

  wire wr_tx = bus_acc & avs_write & sel_tx & ~tx_full_reg;
  wire tx_full_next = (tx_full_reg & ~tx_take) | wr_tx;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_hold_reg <= ssp_pkg::BYTE_RST;
      tx_full_reg <= 1'b0;
      tx_room_reg <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_hold_reg <= avs_writedata[7:0];
      end
      tx_full_reg <= tx_full_next;
      tx_room_reg <= ~tx_full_next;
    end
  end

  assign tx_room_status = tx_room_reg;

  // ==========================================================
  // output strobe and burst counter
  logic [3:0] out_cnt_reg;
  logic oe_drive_reg;

  wire out_open = out_cnt_reg < ssp_pkg::BURST_BITS;
  // burst: rising clock, eight at most, eighth bit then holds
  wire launch_burst = burst & oe_on & dc_rise & out_open;
  // continuous: strobe rises when the clock falls while enabled
  wire launch_cont = ~burst & oe_on & dc_fall;
  wire launch = launch_burst | launch_cont;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_cnt_reg <= 4'h0;
      oe_drive_reg <= 1'b0;
    end else begin
      oe_drive_reg <= oe_on;
      if (!oe_on) begin
        out_cnt_reg <= 4'h0;
      end else if (launch_burst) begin
        out_cnt_reg <= out_cnt_reg + 4'h1;
      end
    end
  end

  assign sync_bit_out_oe = oe_drive_reg;

  // ==========================================================
  // transmit formatter: flags, data, zero insertion
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_left_reg;
  logic tx_empty_reg;
  logic tx_is_data_reg;
  logic [2:0] tx_ones_reg;
  logic [5:0] word_cnt_reg;
  logic out_bit_reg;

  wire stuff_now = tx_is_data_reg & (tx_ones_reg == ssp_pkg::STUFF_RUN);
  wire tx_load = launch & ~stuff_now & tx_empty_reg;
  wire use_data = tx_full_reg & (word_cnt_reg != ssp_pkg::FLAG_EVERY);
  wire [7:0] new_byte = use_data ? tx_hold_reg : ssp_pkg::FLAG_BYTE;
  wire cur_bit = tx_load ? new_byte[0] : tx_sh_reg[0];
  wire cur_data = tx_load ? use_data : tx_is_data_reg;

  assign tx_take = tx_load & use_data;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_sh_reg <= ssp_pkg::BYTE_RST;
      tx_left_reg <= 3'h0;
      tx_empty_reg <= 1'b1;
      tx_is_data_reg <= 1'b0;
      tx_ones_reg <= 3'h0;
      word_cnt_reg <= 6'h00;
      out_bit_reg <= 1'b0;
    end else if (launch && stuff_now) begin
      out_bit_reg <= 1'b0;
      tx_ones_reg <= 3'h0;
    end else if (launch) begin
      out_bit_reg <= cur_bit;
      tx_is_data_reg <= cur_data;
      tx_ones_reg <= (cur_data && cur_bit) ? tx_ones_reg + 3'h1 : 3'h0;
      if (tx_load) begin
        tx_sh_reg <= {1'b0, new_byte[7:1]};
        tx_left_reg <= ssp_pkg::BYTE_LAST;
        tx_empty_reg <= 1'b0;
        word_cnt_reg <= use_data ? word_cnt_reg + 6'h01 : 6'h00;
      end else begin
        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
        tx_left_reg <= tx_left_reg - 3'h1;
        tx_empty_reg <= tx_left_reg == 3'h1;
      end
    end
  end

  assign sync_bit_out = out_bit_reg;

  // ==========================================================
  // input strobe and burst counter
  logic [3:0] in_cnt_reg;

  wire in_open = in_cnt_reg < ssp_pkg::BURST_BITS;
  // burst: falling clock, at most eight per enable window
  wire cap_burst = burst & ie_on & dc_fall & in_open;
  // continuous: nand strobe falls when the clock falls
  wire cap_cont = ~burst & ie_on & dc_fall;
  wire capture = cap_burst | cap_cont;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_cnt_reg <= 4'h0;
    end else if (!ie_on) begin
      in_cnt_reg <= 4'h0;
    end else if (cap_burst) begin
      in_cnt_reg <= in_cnt_reg + 4'h1;
    end
  end

  // ==========================================================
  // receive: flag hunt, zero removal, byte assembly
  logic [7:0] rx_win_reg;
  logic [2:0] rx_ones_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_cnt_reg;
  logic [9:0] gap_reg;
  logic framing_reg;
  logic [7:0] rx_byte_reg;
  logic rx_valid_reg;
  logic rx_ovr_reg;

  wire in_bit = pin_sync_reg.din;
  wire [7:0] win_next = {in_bit, rx_win_reg[7:1]};
  wire flag_seen = capture & (win_next == ssp_pkg::FLAG_BYTE);
  wire drop = ~in_bit & (rx_ones_reg == ssp_pkg::STUFF_RUN);
  wire keep = capture & ~flag_seen & ~drop;
  wire [7:0] sh_next = {in_bit, rx_sh_reg[7:1]};
  wire byte_stb = keep & framing_reg & (rx_cnt_reg == ssp_pkg::BYTE_LAST);
  wire sync_lost = capture & (gap_reg == ssp_pkg::SYNC_LOSS_BITS);

  wire rd_rx = bus_acc & avs_read & sel_rx;
  wire wr_st = bus_acc & avs_write & sel_st;
  wire ovr_clr = wr_st & avs_writedata[ssp_pkg::ST_RX_OVERRUN];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_win_reg <= ssp_pkg::BYTE_RST;
      rx_ones_reg <= 3'h0;
      rx_sh_reg <= ssp_pkg::BYTE_RST;
      rx_cnt_reg <= 3'h0;
      gap_reg <= 10'h000;
      framing_reg <= 1'b0;
    end else if (capture) begin
      rx_win_reg <= win_next;
      if (!in_bit) begin
        rx_ones_reg <= 3'h0;
      end else if (rx_ones_reg != 3'h7) begin
        rx_ones_reg <= rx_ones_reg + 3'h1;
      end
      if (flag_seen) begin
        rx_cnt_reg <= 3'h0;
        gap_reg <= 10'h000;
        framing_reg <= 1'b1;
      end else begin
        if (keep) begin
          rx_sh_reg <= sh_next;
          rx_cnt_reg <= rx_cnt_reg + 3'h1;
        end
        if (sync_lost) begin
          framing_reg <= 1'b0;
        end else begin
          gap_reg <= gap_reg + 10'h001;
        end
      end
    end
  end

  // received byte holding word, new byte wins over a read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_byte_reg <= ssp_pkg::BYTE_RST;
      rx_valid_reg <= 1'b0;
      rx_ovr_reg <= 1'b0;
    end else begin
      if (byte_stb) begin
        rx_byte_reg <= sh_next;
      end
      rx_valid_reg <= byte_stb | (rx_valid_reg & ~rd_rx);
      rx_ovr_reg <= (byte_stb & rx_valid_reg & ~rd_rx) |
                    (rx_ovr_reg & ~ovr_clr);
    end
  end

  assign rx_framing_status = framing_reg;

  // ==========================================================
  // read data
  logic [31:0] st_word;

  always_comb begin
    st_word = ssp_pkg::WORD_RST;
    st_word[ssp_pkg::ST_TX_ROOM] = tx_room_reg;
    st_word[ssp_pkg::ST_RX_FRAMING] = framing_reg;
    st_word[ssp_pkg::ST_RX_VALID] = rx_valid_reg;
    st_word[ssp_pkg::ST_RX_OVERRUN] = rx_ovr_reg;
  end

  assign rdata_mux = sel_tx ? {24'h000000, tx_hold_reg} :
                     sel_rx ? {24'h000000, rx_byte_reg} :
                     sel_st ? st_word : ssp_pkg::WORD_RST;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rdata_reg <= ssp_pkg::WORD_RST;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read && !ack_reg) begin
        rdata_reg <= rdata_mux;
      end
    end
  end

endmodule : ssp_sync_port
